// file: erb_defines.vh
// Purpose: Shared constants for the embedded RAM block and its APB registers
// Assumes: 32-bit APB data, registers on aligned words
// Notes:   Definitions only
`ifndef ERB_DEFINES_VH
`define ERB_DEFINES_VH

// ============================================================
// Register byte offsets
`define ERB_OFS_CTRL      12'h000
`define ERB_OFS_STATUS    12'h004
`define ERB_OFS_LOAD_ADDR 12'h008
`define ERB_OFS_LOAD_DATA 12'h00c

// ============================================================
// Control register fields
`define ERB_CTRL_SHAPE_LO 0
`define ERB_CTRL_SHAPE_HI 1
`define ERB_CTRL_DUAL     2
`define ERB_CTRL_LUT      3
`define ERB_CTRL_DONE     4
`define ERB_CTRL_RESET    5'h00

// ============================================================
// Shapes: words by bits
`define ERB_SHAPE_256X16  2'h0
`define ERB_SHAPE_512X8   2'h1
`define ERB_SHAPE_1024X4  2'h2
`define ERB_SHAPE_2048X2  2'h3

// ============================================================
// Sizes
`define ERB_WORD_W        16
`define ERB_INDEX_W       8
`define ERB_ADDR_W        11
`define ERB_LOAD_RESET    8'h00

`endif

// file: erb_mem.v
// Purpose: Physical storage of the RAM block, 256 words of 16 bits
// Assumes: One clock, one write port with bit mask, one read port
// Notes:   Read data comes out of a register
`timescale 1ns/100ps
`default_nettype none

module erb_mem #(
  parameter DEPTH_W = 8,
  parameter WIDTH   = 16
) (
  // Clock
  input  wire               pclk,
  // Write port
  input  wire               wr_en,
  input  wire [DEPTH_W-1:0] wr_index,
  input  wire [WIDTH-1:0]   wr_data,
  input  wire [WIDTH-1:0]   wr_mask,
  // Read port
  input  wire               rd_en,
  input  wire [DEPTH_W-1:0] rd_index,
  output reg  [WIDTH-1:0]   rd_data
);

  // ============================================================
  // Storage array
  reg [WIDTH-1:0] mem_reg [0:(1<<DEPTH_W)-1];

  // Masked write, only the selected bits change
  always @(posedge pclk) begin
    if (wr_en) begin
      mem_reg[wr_index] <= (mem_reg[wr_index] & ~wr_mask) | (wr_data & wr_mask);
    end
  end

  // Registered read; same-index collision returns either value
  always @(posedge pclk) begin
    if (rd_en) begin
      rd_data <= mem_reg[rd_index];
    end
  end

endmodule // erb_mem

`default_nettype wire

// file: erb_ram_block.v
// Purpose: Configurable RAM or lookup block with registered ports and APB setup
// Assumes: All user inputs synchronous to pclk; APB slave with no wait states
// Notes:   Read latency is two pclk edges after the sampled read request
//
// How it works
// - Inputs and read result are registered
// - Lookup contents loaded at setup, then read-only
// - Lookup: eight address bits, sixteen result bits
// - Single-port or independent dual-port sections
// - Each section runs at its own rate
// - Per-section synchronous enables; in single-port mode reads use the address taken on the write enable
// - Shapes 256x16, 512x8, 1024x4, 2048x2
// - Blocks side by side widen words
// - Depth cascade via select, no extra latency
`timescale 1ns/100ps
`default_nettype none
`include "erb_defines.vh"

module erb_ram_block #(
  parameter ADDR_W = `ERB_ADDR_W,
  parameter WORD_W = `ERB_WORD_W
) (
  // Clock and reset
  input  wire              pclk,
  input  wire              presetn,
  // APB slave
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [11:0]       paddr,
  input  wire [31:0]       pwdata,
  output wire              pready,
  output wire              pslverr,
  output reg  [31:0]       prdata,
  // Block select for depth cascades
  input  wire              blk_sel,
  // Write section
  input  wire              wr_clk_en,
  input  wire              wr_req,
  input  wire [ADDR_W-1:0] wr_addr,
  input  wire [WORD_W-1:0] wr_data,
  // Read section
  input  wire              rd_clk_en,
  input  wire              rd_req,
  input  wire [ADDR_W-1:0] rd_addr,
  output reg  [WORD_W-1:0] rd_data,
  output reg               rd_valid
);

  // ============================================================
  // Shape helpers

  // Physical word index for a logical address
  function [7:0] phys_index;
    input [1:0]  shape;
    input [10:0] addr;
    begin
      case (shape)
        `ERB_SHAPE_256X16: phys_index = addr[7:0];
        `ERB_SHAPE_512X8:  phys_index = addr[8:1];
        `ERB_SHAPE_1024X4: phys_index = addr[9:2];
        default:           phys_index = addr[10:3];
      endcase
    end
  endfunction

  // Bit offset of the lane inside the physical word
  function [3:0] lane_ofs;
    input [1:0]  shape;
    input [10:0] addr;
    begin
      case (shape)
        `ERB_SHAPE_256X16: lane_ofs = 4'h0;
        `ERB_SHAPE_512X8:  lane_ofs = {addr[0], 3'h0};
        `ERB_SHAPE_1024X4: lane_ofs = {addr[1:0], 2'h0};
        default:           lane_ofs = {addr[2:0], 1'h0};
      endcase
    end
  endfunction

  // Mask of the lane bits inside the physical word
  function [15:0] lane_mask;
    input [1:0]  shape;
    input [10:0] addr;
    begin
      case (shape)
        `ERB_SHAPE_256X16: lane_mask = 16'hffff;
        `ERB_SHAPE_512X8:  lane_mask = 16'h00ff << lane_ofs(shape, addr);
        `ERB_SHAPE_1024X4: lane_mask = 16'h000f << lane_ofs(shape, addr);
        default:           lane_mask = 16'h0003 << lane_ofs(shape, addr);
      endcase
    end
  endfunction

  // Narrow data repeated across every lane
  function [15:0] lane_fill;
    input [1:0]  shape;
    input [15:0] d;
    begin
      case (shape)
        `ERB_SHAPE_256X16: lane_fill = d;
        `ERB_SHAPE_512X8:  lane_fill = {2{d[7:0]}};
        `ERB_SHAPE_1024X4: lane_fill = {4{d[3:0]}};
        default:           lane_fill = {8{d[1:0]}};
      endcase
    end
  endfunction

  // ============================================================
  // Registers and state
  reg  [4:0]  ctrl_reg;       // Shape, dual, lookup, setup done
  reg  [7:0]  load_addr_reg;  // Next word loaded over APB
  reg         ld_en_reg;      // Pending setup load
  reg  [7:0]  ld_index_reg;   // Setup load word index
  reg  [15:0] ld_data_reg;    // Setup load data
  reg         wr_go_reg;      // Sampled write request
  reg  [10:0] wr_addr_reg;    // Sampled write address
  reg  [15:0] wr_data_reg;    // Sampled write data
  reg         rd_go_reg;      // Sampled read request
  reg  [10:0] rd_addr_reg;    // Sampled read address
  reg         rd_mem_reg;     // Memory read in flight
  reg  [10:0] rd_addr_q_reg;  // Address following the memory stage
  wire [15:0] mem_q;          // Raw memory word
  wire [1:0]  shape;          // Effective shape
  wire        dual;           // Dual-port mode
  wire        lut_mode;       // Lookup mode
  wire        cfg_done;       // Setup finished
  wire        apb_wr;         // APB write access phase
  wire        apb_rd;         // APB read access phase
  wire        user_wr;        // User write reaches the memory
  wire [10:0] rd_sel_addr;    // Read address per port mode
  wire        mapped;         // Address hits a register

  // Lookup mode pins the shape to 256 words by 16 bits
  assign shape    = ctrl_reg[`ERB_CTRL_LUT] ? `ERB_SHAPE_256X16 :
                    ctrl_reg[`ERB_CTRL_SHAPE_HI:`ERB_CTRL_SHAPE_LO];
  assign dual     = ctrl_reg[`ERB_CTRL_DUAL];
  assign lut_mode = ctrl_reg[`ERB_CTRL_LUT];
  assign cfg_done = ctrl_reg[`ERB_CTRL_DONE];

  // ============================================================
  // APB slave, no wait states
  assign pready  = 1'b1;
  assign apb_wr  = psel & penable & pwrite;
  assign apb_rd  = psel & penable & ~pwrite;
  assign mapped  = (paddr == `ERB_OFS_CTRL) | (paddr == `ERB_OFS_STATUS) |
                   (paddr == `ERB_OFS_LOAD_ADDR) | (paddr == `ERB_OFS_LOAD_DATA);
  assign pslverr = psel & penable & ~mapped;

  // Control writes; setup done is sticky until reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg      <= `ERB_CTRL_RESET;
      load_addr_reg <= `ERB_LOAD_RESET;
      ld_en_reg     <= 1'b0;
      ld_index_reg  <= `ERB_LOAD_RESET;
      ld_data_reg   <= 16'h0000;
    end else begin
      ld_en_reg <= 1'b0;
      if (apb_wr && paddr == `ERB_OFS_CTRL && !cfg_done) begin
        // Mode and shape frozen once setup is done
        ctrl_reg <= pwdata[4:0];
      end
      if (apb_wr && paddr == `ERB_OFS_LOAD_ADDR && !cfg_done) begin
        load_addr_reg <= pwdata[7:0];
      end
      if (apb_wr && paddr == `ERB_OFS_LOAD_DATA && !cfg_done) begin
        // Contents loaded only during setup, then the address steps
        ld_en_reg     <= 1'b1;
        ld_index_reg  <= load_addr_reg;
        ld_data_reg   <= pwdata[15:0];
        load_addr_reg <= load_addr_reg + 8'h01;
      end
    end
  end

  // Read data register, zero for unmapped addresses
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `ERB_OFS_CTRL:      prdata <= {27'h0, ctrl_reg};
        `ERB_OFS_STATUS:    prdata <= {27'h0, cfg_done, lut_mode, dual, shape};
        `ERB_OFS_LOAD_ADDR: prdata <= {24'h0, load_addr_reg};
        default:            prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ============================================================
  // Input registers of both sections
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_go_reg   <= 1'b0;
      wr_addr_reg <= 11'h000;
      wr_data_reg <= 16'h0000;
      rd_go_reg   <= 1'b0;
      rd_addr_reg <= 11'h000;
    end else begin
      // Write section advances only on its own enable
      wr_go_reg <= wr_clk_en & wr_req & blk_sel;
      if (wr_clk_en) begin
        wr_addr_reg <= wr_addr;
        wr_data_reg <= wr_data;
      end
      // Read section advances only on its own enable
      rd_go_reg <= rd_clk_en & rd_req & blk_sel;
      if (rd_clk_en) begin
        rd_addr_reg <= rd_addr;
      end
    end
  end

  // Lookup tables never take user writes
  assign user_wr     = wr_go_reg & cfg_done & ~lut_mode;
  // Single-port mode shares the write address for reads
  assign rd_sel_addr = dual ? rd_addr_reg : wr_addr_reg;

  // ============================================================
  // Storage; setup loads and user writes never overlap in time
  erb_mem #(
    .DEPTH_W (`ERB_INDEX_W),
    .WIDTH   (`ERB_WORD_W)
  ) u_mem (
    .pclk     (pclk),
    .wr_en    (ld_en_reg | user_wr),
    .wr_index (ld_en_reg ? ld_index_reg : phys_index(shape, wr_addr_reg)),
    .wr_data  (ld_en_reg ? ld_data_reg : lane_fill(shape, wr_data_reg)),
    .wr_mask  (ld_en_reg ? 16'hffff : lane_mask(shape, wr_addr_reg)),
    .rd_en    (rd_go_reg & cfg_done),
    .rd_index (phys_index(shape, rd_sel_addr)),
    .rd_data  (mem_q)
  );

  // ============================================================
  // Output register: lane select, zero when idle so cascades can be ORed
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_mem_reg    <= 1'b0;
      rd_addr_q_reg <= 11'h000;
      rd_data       <= {WORD_W{1'b0}};
      rd_valid      <= 1'b0;
    end else begin
      rd_mem_reg    <= rd_go_reg & cfg_done;
      rd_addr_q_reg <= rd_sel_addr;
      rd_valid      <= rd_mem_reg;
      if (rd_mem_reg) begin
        // Same-address collision: data may be old or new
        rd_data <= (mem_q & lane_mask(shape, rd_addr_q_reg))
                   >> lane_ofs(shape, rd_addr_q_reg);
      end else begin
        rd_data <= {WORD_W{1'b0}};
      end
    end
  end

endmodule // erb_ram_block

`default_nettype wire

// file: erb_ram_block_checker.sv
// Purpose: Port assertions for the RAM block
// Assumes: One pclk domain
// Notes:   Bound to every block instance
`timescale 1ns/100ps
`default_nettype none
module erb_ram_block_checker #(
  parameter WORD_W = 16
) (
  // Clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // APB
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [11:0]       paddr,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [31:0]       prdata,
  // Read section
  input wire logic              blk_sel,
  input wire logic              rd_clk_en,
  input wire logic              rd_req,
  input wire logic [WORD_W-1:0] rd_data,
  input wire logic              rd_valid
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ============================================================
  // APB answers
  pready_high_a: assert property (pready)
    else $error("pready low");
  err_phase_a: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  err_unmapped_a: assert property (psel && penable && paddr[11:4] != 8'h00 |-> pslverr)
    else $error("no pslverr on unmapped");
  zero_unmapped_a: assert property (psel && penable && !pwrite && paddr[11:4] != 8'h00
    |-> prdata == 32'h0) else $error("unmapped read not zero");
  prdata_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("prdata moved");
  status_top_a: assert property (psel && penable && !pwrite && paddr == 12'h004
    |-> prdata[31:5] == 27'h0) else $error("status upper bits");
  // ============================================================
  // Read results: three edges after an accepted request
  rd_latency_a: assert property (rd_valid |-> $past(rd_req, 3)
    && $past(rd_clk_en, 3) && $past(blk_sel, 3)) else $error("result without request");
  rd_idle_a: assert property (!rd_valid |-> rd_data == '0)
    else $error("rd_data not zero");
endmodule // erb_ram_block_checker
bind erb_ram_block erb_ram_block_checker #(.WORD_W(WORD_W)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .prdata(prdata), .blk_sel(blk_sel),
  .rd_clk_en(rd_clk_en), .rd_req(rd_req), .rd_data(rd_data), .rd_valid(rd_valid));
`default_nettype wire

// file: erb_user_model.sv
// Purpose: User logic beside the RAM block
// Assumes: Driven one op per pclk edge
// Notes:   Unused data lines toggle
`timescale 1ns/100ps
`default_nettype none
module erb_user_model (
  // Clock
  input  wire logic        pclk,
  // Write section
  output logic        wr_clk_en,
  output logic        wr_req,
  output logic [10:0] wr_addr,
  output logic [15:0] wr_data,
  // Read section
  output logic        rd_clk_en,
  output logic        rd_req,
  output logic [10:0] rd_addr
);
  // Quiet lines at time zero
  initial begin
    {wr_clk_en, wr_req, rd_clk_en, rd_req, wr_addr, wr_data, rd_addr} = '0;
  end
  // One cycle of requests; never lowered inside, so calls chain back to back
  task automatic op(input logic we, input logic re, input logic [10:0] a,
                    input logic [15:0] d, input logic wen, input logic ren);
    wr_clk_en <= wen;
    wr_req    <= we;
    wr_addr   <= a;
    wr_data   <= we ? d : ~wr_data;
    rd_clk_en <= ren;
    rd_req    <= re;
    rd_addr   <= re ? a : ~rd_addr;
    @(posedge pclk);
  endtask
endmodule // erb_user_model
`default_nettype wire

// file: configurable_dual_port_ram_block_tb_top.sv
// Purpose: Self-checking bench for the RAM block
// Assumes: APB setup, then user traffic
// Notes:   Integer model of the storage
`timescale 1ns/100ps
`default_nettype none
module configurable_dual_port_ram_block_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, blk_sel, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  wire  [31:0] prdata;
  wire         pready, pslverr, wr_clk_en, wr_req, rd_clk_en, rd_req, rd_valid;
  wire  [10:0] wr_addr, rd_addr;
  wire  [15:0] wr_data, rd_data;
  int          err_count, check_count, seed, es, lut_m, done_m, i, k, r;
  int          mem [256];
  logic [15:0] exp_q [$];
  logic [4:0]  cfgs [5] = '{5'h04, 5'h05, 5'h02, 5'h07, 5'h0f};
  erb_ram_block u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .blk_sel(blk_sel), .wr_clk_en(wr_clk_en), .wr_req(wr_req),
    .wr_addr(wr_addr), .wr_data(wr_data), .rd_clk_en(rd_clk_en), .rd_req(rd_req),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid));
  erb_user_model u_user (.pclk(pclk), .wr_clk_en(wr_clk_en), .wr_req(wr_req),
    .wr_addr(wr_addr), .wr_data(wr_data), .rd_clk_en(rd_clk_en), .rd_req(rd_req),
    .rd_addr(rd_addr));
  always #10 pclk = ~pclk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // APB master: setup, access until pready, then release
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int t;
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    t = 0;
    do begin @(posedge pclk); t++; end while (pready !== 1'b1 && t < 20);
    if (pready !== 1'b1) begin
      err_count++;
      summarize;
    end else begin
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
    end
  endtask
  // ============================================================
  // Storage model: lane of a word for the current shape
  function automatic logic [15:0] lane(input int a);
    int w;
    w = 16 >> es;
    return 16'((mem[a >> es] >> ((a & ((1 << es) - 1)) * w)) & ((1 << w) - 1));
  endfunction
  task automatic uop(input logic we, re, input int a, d, input logic en, bs);
    int w, sh;
    w = 16 >> es;
    sh = (a & ((1 << es) - 1)) * w;
    if (we && en && bs && done_m && !lut_m)
      mem[a >> es] = (mem[a >> es] & ~(((1 << w) - 1) << sh)) | ((d & ((1 << w) - 1)) << sh);
    if (re && en && bs && done_m) exp_q.push_back(lane(a));
    blk_sel <= bs;
    u_user.op(we, re, 11'(a), 16'(d), we ? en : 1'b1, re ? en : 1'b0);
  endtask
  task automatic drain;
    int t;
    u_user.op(0, 0, 0, 0, 0, 0);
    for (t = 0; t < 10 && exp_q.size() > 0; t++) @(posedge pclk);
    check(32'(exp_q.size()), 0);
  endtask
  // Every read result against the model
  always @(posedge pclk) begin
    if (rd_valid === 1'b1 && exp_q.size() == 0) check(1, 0);
    else if (rd_valid === 1'b1) check({16'h0, rd_data}, {16'h0, exp_q.pop_front()});
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn, pclk} = '0;
    blk_sel = 1; err_count = 0; check_count = 0; seed = 10;
    for (k = 0; k < 5; k++) begin
      presetn <= 0;
      repeat (4) @(posedge pclk);
      presetn <= 1;
      done_m = 0; lut_m = cfgs[k][3]; es = lut_m ? 0 : cfgs[k][1:0];
      @(posedge pclk);
      apb(0, 12'h004, 0);
      check(rd, 0);
      uop(1, 0, 1, 16'h1234, 1, 1);
      uop(0, 1, 1, 0, 1, 1);
      drain;
      apb(1, 12'h000, 32'(cfgs[k]));
      apb(1, 12'h008, 0);
      for (i = 0; i < 256; i++) begin
        mem[i] = $random(seed) & 16'hffff;
        apb(1, 12'h00c, mem[i]);
      end
      apb(1, 12'h000, 32'(cfgs[k]) | 32'h10);
      done_m = 1;
      for (i = 0; i < 3; i++) begin
        apb(1, i == 2 ? 12'h00c : 12'(4 * i), 0);
        apb(0, 12'h004, 0);
        check(rd, {27'h0, 1'b1, cfgs[k][3:2], 2'(es)});
      end
      // Control reads back as written with setup done; load index wrapped after 256 words
      apb(0, 12'h000, 0);
      check(rd, {27'h0, cfgs[k] | 5'h10});
      apb(0, 12'h008, 0);
      check(rd, 0);
      apb(0, 12'h010, 0);
      check({rd[30:0], er}, 1);
      uop(1, 0, 3, $random(seed), 1, 1);
      uop(0, 1, 3, 0, 1, 1);
      for (i = 0; i < 80; i++) begin
        r = $random(seed);
        uop(r[0], !r[0], (r >> 8) & ((256 << es) - 1), r >> 16, |r[3:1], |r[6:4]);
      end
      drain;
    end
    summarize;
  end
endmodule // configurable_dual_port_ram_block_tb_top
`default_nettype wire
